// [hdl/extended_address_mux_mode_dev.sv]
// flash side of the extended address mux port
//
// Behaviour
// - config bit 4 enables extended mode
// - reset leaves plain mux mode
// - enabling clears upper address latch
// - oe high latches low, low latches upper
// - host sends upper first, lower second
// - lower-only cycle reuses held upper
// - sensing starts at lower address latch
// - lower latched oe high, data after fall
// - wait driven exactly with data lines
// - async wait always valid, sync after latency
// - bit 10 zero gives active-low wait
// - host pulses address valid once or twice
// - two pulses capture upper then lower
// - host restarts read at most once
// - sync mode latches on clock edge
// - sync mode: valid may stay low both halves
// - host times oe like address valid
// - oe ordering ends address phase
// - host drives oe after address hold
// - works with slow link clock
`timescale 1ns/1ps
`default_nettype none
module xam_dev
    import xam_pkg::*;
#(
    parameter int HIW = xam_pkg::HI_W,
    parameter int LATENCY = xam_pkg::LATENCY_DEF,
    parameter int SENSE = xam_pkg::SENSE_DEF
) (
    // system side
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [xam_pkg::CFG_W-1:0] cfg,
    input wire logic mux_strap,
    // captured address and array data
    output logic [HIW+xam_pkg::DATA_W-1:0] addr_out,
    output logic sense_start,
    input wire logic [xam_pkg::DATA_W-1:0] array_data,
    // link pins
    xam_if.dev bus
);
    import xam_pkg::*;
    // ----------------------------------------
    // parameter limits
    // ----------------------------------------
    // counters are eight bits wide; upper half comes off the data lines
    if (LATENCY < 1 || LATENCY > 255) begin : g_bad_latency
        $error("latency out of range");
    end
    if (SENSE < 1 || SENSE > 255) begin : g_bad_sense
        $error("sense time out of range");
    end
    if (HIW < 1 || HIW > DATA_W) begin : g_bad_hiw
        $error("upper address width out of range");
    end
    // ----------------------------------------
    // config from system domain
    // ----------------------------------------
    // limitation: config is quasi-static, change it only while the link is idle
    logic [CFG_W-1:0] cfg_s;
    logic strap_s;
    // reset must read as reset config, not as sync mode
    xam_sync2 #(.W(CFG_W), .INIT(CFG_RESET)) u_cfg (.clk(bus.link_clk), .rst(rst), .d(cfg), .q(cfg_s));
    xam_sync2 #(.W(1)) u_strap (.clk(bus.link_clk), .rst(rst), .d(mux_strap), .q(strap_s));
    logic ext_en;
    logic async_m;
    logic ext_en_r;
    assign ext_en = cfg_s[CFG_EXT_BIT] & strap_s;
    assign async_m = cfg_s[CFG_ASYNC_BIT];
    // ----------------------------------------
    // address capture on the link clock
    // ----------------------------------------
    // link clock runs free here; async edges seen by sampling valid
    logic adv_q_r;
    logic [HIW-1:0] hi_r;
    logic [DATA_W-1:0] lo_r;
    logic lo_ev;
    logic hi_ev;
    logic cap;
    logic oe_q_r;
    logic sync_cap;
    // sync: first low edge, or an oe change while valid stays low;
    // a two-clock pulse must not restart sensing on its second edge
    assign sync_cap = ~bus.address_valid_n & (adv_q_r | (oe_q_r ^ bus.output_enable_n));
    // async: valid rising; sync: first clock edge with valid low, or an oe change while it stays low
    assign cap = async_m ? (~adv_q_r & bus.address_valid_n) : sync_cap;
    // with the mode off an oe-low capture is ignored, not taken as lower
    assign lo_ev = cap & bus.output_enable_n;
    assign hi_ev = cap & ~bus.output_enable_n & ext_en;
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            adv_q_r <= 1'b1;
            oe_q_r <= 1'b1;
            ext_en_r <= 1'b0;
        end else if (ce) begin
            adv_q_r <= bus.address_valid_n;
            oe_q_r <= bus.output_enable_n;
            ext_en_r <= ext_en;
        end
    end
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            hi_r <= '0;
        end else if (ce) begin
            if (ext_en & ~ext_en_r) begin
                hi_r <= '0;
            end else if (hi_ev) begin
                hi_r <= bus.ad[HIW-1:0];
            end
        end
    end
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            lo_r <= '0;
        end else if (ce && lo_ev) begin
            lo_r <= bus.ad;
        end
    end
    // ----------------------------------------
    // sensing and latency
    // ----------------------------------------
    logic [7:0] sense_cnt_r;
    logic [7:0] lat_cnt_r;
    logic sense_go_r;
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            sense_cnt_r <= '0;
            sense_go_r <= 1'b0;
        end else if (ce) begin
            sense_go_r <= lo_ev;
            // a restart reloads the count; the host restarts only once
            if (lo_ev) begin
                sense_cnt_r <= 8'(SENSE);
            end else if (sense_cnt_r != 8'h00) begin
                sense_cnt_r <= sense_cnt_r - 8'h01;
            end
        end
    end
    logic drive;
    // drive only once oe falls after the address phase
    assign drive = ~bus.output_enable_n & bus.address_valid_n & adv_q_r & ~hi_ev;
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            lat_cnt_r <= '0;
        end else if (ce) begin
            if (lo_ev) begin
                lat_cnt_r <= 8'(LATENCY);
            end else if (drive && lat_cnt_r != 8'h00) begin
                lat_cnt_r <= lat_cnt_r - 8'h01;
            end
        end
    end
    logic valid_now;
    assign valid_now = async_m | (lat_cnt_r == 8'h00);
    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            bus.ad_dev_oe <= 1'b0;
            bus.wait_oe <= 1'b0;
            bus.ad_dev_o <= '0;
            bus.wait_o <= 1'b0;
        end else if (ce) begin
            // one registered term keeps data and wait enables in step
            bus.ad_dev_oe <= drive;
            bus.wait_oe <= drive;
            bus.ad_dev_o <= array_data;
            // wait level means data valid; polarity per bit 10
            bus.wait_o <= cfg_s[CFG_WPOL_BIT] ? valid_now : ~valid_now;
        end
    end
    // ----------------------------------------
    // address back to system domain
    // ----------------------------------------
    // toggle crossing; address stays stable until the next sense
    logic tog_r;
    logic [HIW+DATA_W-1:0] addr_hold_r;
    always_ff @(posedge bus.link_clk or posedge rst) begin
        if (rst) begin
            tog_r <= 1'b0;
            addr_hold_r <= '0;
        end else if (ce && sense_go_r) begin
            tog_r <= ~tog_r;
            addr_hold_r <= {hi_r & {HIW{ext_en}}, lo_r};
        end
    end
    logic tog_s;
    logic tog_d_r;
    xam_sync2 #(.W(1)) u_tog (.clk(sys_clk), .rst(rst), .d(tog_r), .q(tog_s));
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tog_d_r <= 1'b0;
            sense_start <= 1'b0;
            addr_out <= '0;
        end else if (ce) begin
            tog_d_r <= tog_s;
            sense_start <= tog_s ^ tog_d_r;
            if (tog_s ^ tog_d_r) begin
                addr_out <= addr_hold_r;
            end
        end
    end
endmodule : xam_dev
`default_nettype wire

// [hdl/extended_address_mux_mode_pkg.sv]
// shared constants for the extended address mux port
package xam_pkg;
    localparam int DATA_W = 16;
    localparam int HI_W = 8;
    localparam int CFG_W = 16;
    // read configuration register field positions
    localparam int CFG_EXT_BIT = 4;
    localparam int CFG_WPOL_BIT = 10;
    localparam int CFG_ASYNC_BIT = 15;
    // reset value: async mode, extended mode off
    localparam logic [15:0] CFG_RESET = 16'h8000;
    // latency count and sense time in link clocks
    localparam int LATENCY_DEF = 4;
    localparam int SENSE_DEF = 6;
    // slowest supported burst clock, kHz
    localparam int MIN_LINK_KHZ = 9600;
    // host divider: 200 MHz / 2 / DIV
    localparam int DIV_DEF = 10;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_DATA = 2'b10
    } host_st_e;
endpackage : xam_pkg

// [hdl/extended_address_mux_mode_if.sv]
// pins between the host and the extended address flash port
`timescale 1ns/1ps
`default_nettype none
interface xam_if;
    logic link_clk;
    logic address_valid_n;
    logic output_enable_n;
    logic [15:0] ad_host_o;
    logic ad_host_oe;
    logic [15:0] ad_dev_o;
    logic ad_dev_oe;
    logic wait_o;
    logic wait_oe;
    logic [15:0] ad;
    logic wait_pin;
    assign ad = ad_dev_oe ? ad_dev_o : ad_host_o;
    assign wait_pin = wait_oe ? wait_o : 1'b1;
    modport dev (input link_clk, address_valid_n, output_enable_n, ad,
                 output ad_dev_o, ad_dev_oe, wait_o, wait_oe);
    modport host (output link_clk, address_valid_n, output_enable_n, ad_host_o, ad_host_oe,
                  input ad, wait_pin);
endinterface : xam_if
`default_nettype wire

// [hdl/extended_address_mux_mode_sync2.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module xam_sync2 #(
    parameter int W = 1,
    // level shown while in reset
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // level in and out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : xam_sync2
`default_nettype wire

// [hdl/extended_address_mux_mode_host.sv]
// host controller side of the extended address mux port
`timescale 1ns/1ps
`default_nettype none
module xam_host
    import xam_pkg::*;
#(
    parameter int HIW = xam_pkg::HI_W,
    parameter int DIV = xam_pkg::DIV_DEF
) (
    // system side
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // read request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_two,
    input wire logic [HIW+xam_pkg::DATA_W-1:0] req_addr,
    output logic [xam_pkg::DATA_W-1:0] rsp_data,
    output logic rsp_valid,
    // link pins
    xam_if.host bus
);
    import xam_pkg::*;
    // divider counter is eight bits wide
    if (DIV < 1 || DIV > 256) begin : g_bad_div
        $error("divider out of range");
    end
    // host makes the link clock, so it is no second domain here
    logic [7:0] div_r;
    logic lclk_r;
    logic tick;
    // pins change as the link clock falls, half a period before the device samples
    assign tick = (div_r == 8'(DIV - 1)) & lclk_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
            lclk_r <= 1'b0;
        end else if (ce) begin
            if (div_r == 8'(DIV - 1)) begin
                div_r <= '0;
                lclk_r <= ~lclk_r;
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end
    assign bus.link_clk = lclk_r;
    logic [15:0] ad_s;
    logic wait_s;
    xam_sync2 #(.W(17)) u_in (.clk(sys_clk), .rst(rst), .d({bus.wait_pin, bus.ad}), .q({wait_s, ad_s}));
    host_st_e st_r;
    logic [1:0] phase_r;
    logic [3:0] dcnt_r;
    assign req_ready = (st_r == ST_IDLE);
    // one or two valid pulses, upper half first, oe low for it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            phase_r <= '0;
            dcnt_r <= '0;
            bus.address_valid_n <= 1'b1;
            bus.output_enable_n <= 1'b1;
            bus.ad_host_o <= '0;
            bus.ad_host_oe <= 1'b0;
            rsp_data <= '0;
            rsp_valid <= 1'b0;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        st_r <= ST_LOW;
                        phase_r <= req_two ? 2'b00 : 2'b01;
                    end
                end
                ST_LOW: begin
                    if (tick) begin
                        if (bus.address_valid_n) begin
                            bus.address_valid_n <= 1'b0;
                            bus.ad_host_oe <= 1'b1;
                            bus.output_enable_n <= phase_r[0];
                            bus.ad_host_o <= phase_r[0] ? req_addr[15:0] : 16'(req_addr[HIW+15:16]);
                        end else begin
                            // oe stays low across the upper rising edge
                            bus.address_valid_n <= 1'b1;
                            if (phase_r[0]) begin
                                st_r <= ST_DATA;
                                dcnt_r <= '0;
                            end
                            phase_r <= 2'b01;
                        end
                    end
                end
                ST_DATA: begin
                    // release bus past the hold before oe falls
                    bus.ad_host_oe <= 1'b0;
                    if (tick) begin
                        bus.output_enable_n <= 1'b0;
                        dcnt_r <= dcnt_r + 4'h1;
                        if (dcnt_r == 4'hf) begin
                            rsp_data <= ad_s;
                            rsp_valid <= 1'b1;
                            bus.output_enable_n <= 1'b1;
                            st_r <= ST_IDLE;
                        end
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule : xam_host
`default_nettype wire

// [verification/extended_address_mux_mode_chk.sv]
// link pin assertions for the extended address mux port
`timescale 1ns/1ps
`default_nettype none
module xam_chk (
    // link clock and reset
    input wire logic link_clk,
    input wire logic rst,
    // strobes and drivers
    input wire logic address_valid_n,
    input wire logic output_enable_n,
    input wire logic ad_host_oe,
    input wire logic ad_dev_oe,
    input wire logic wait_oe
);
    // ----------------------------------------
    // properties on the link clock
    // ----------------------------------------
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (rst);
    sequence s_upper;
        $rose(address_valid_n) && !output_enable_n;
    endsequence
    sequence s_lower;
        $rose(address_valid_n) && output_enable_n;
    endsequence
    property p_wait_follows;
        wait_oe == ad_dev_oe;
    endproperty
    property p_no_fight;
        !(ad_dev_oe && ad_host_oe);
    endproperty
    // enable is registered, so allow one edge after oe_n rises
    property p_dev_release;
        output_enable_n && $past(output_enable_n) |-> !ad_dev_oe;
    endproperty
    property p_pulse_len;
        $fell(address_valid_n) |-> ##[1:2] address_valid_n;
    endproperty
    property p_addr_driven;
        !address_valid_n |-> ad_host_oe;
    endproperty
    property p_upper_lower;
        s_upper |-> ##[1:8] s_lower;
    endproperty
    property p_data_after;
        s_lower |-> ##[1:8] !output_enable_n;
    endproperty
    property p_quiet_addr;
        !address_valid_n && output_enable_n |-> !ad_dev_oe;
    endproperty
    a_wait_follows: assert property (p_wait_follows)
        else $error("wait enable differs from data enable");
    a_no_fight: assert property (p_no_fight)
        else $error("both ends drive the bus");
    a_dev_release: assert property (p_dev_release)
        else $error("device drives with oe_n high");
    a_pulse_len: assert property (p_pulse_len)
        else $error("address valid pulse too long");
    a_addr_driven: assert property (p_addr_driven)
        else $error("address not driven while valid");
    a_upper_lower: assert property (p_upper_lower)
        else $error("upper capture not followed by lower");
    a_data_after: assert property (p_data_after)
        else $error("oe_n not lowered after lower address");
    a_quiet_addr: assert property (p_quiet_addr)
        else $error("device drives during address phase");
endmodule : xam_chk
`default_nettype wire

// [verification/muxed_bus_high_address_capture_bench.sv]
// self-checking bench joining host and flash ends of the port
`timescale 1ns/1ps
`default_nettype none
module muxed_bus_high_address_capture_bench;
    import xam_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [CFG_W-1:0] cfg = CFG_RESET;
    logic mux_strap = 1'b1;
    logic req_valid = 1'b0;
    logic req_two = 1'b0;
    logic [HI_W+DATA_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] array_data = '0;
    logic req_ready, rsp_valid, sense_start;
    logic [DATA_W-1:0] rsp_data;
    logic [HI_W+DATA_W-1:0] addr_out;
    logic [HI_W-1:0] hi_m = '0;
    int n_mismatch = 0, n_tests = 0, n_sense = 0, cyc = 0, n_drv = 0;
    always #2.5 sys_clk = ~sys_clk;
    xam_if bus ();
    xam_host #(.DIV(2)) xam_host_i (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .req_valid(req_valid),
        .req_ready(req_ready), .req_two(req_two), .req_addr(req_addr), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .bus(bus.host));
    xam_dev xam_dev_i (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .cfg(cfg), .mux_strap(mux_strap),
        .addr_out(addr_out), .sense_start(sense_start), .array_data(array_data), .bus(bus.dev));
    xam_chk xam_chk_i (.link_clk(bus.link_clk), .rst(rst), .address_valid_n(bus.address_valid_n),
        .output_enable_n(bus.output_enable_n), .ad_host_oe(bus.ad_host_oe), .ad_dev_oe(bus.ad_dev_oe),
        .wait_oe(bus.wait_oe));
    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (sense_start === 1'b1) n_sense <= n_sense + 1;
        if (cyc == 60000) begin
            n_mismatch++;
            conclude();
        end
    end
    // driven wait: valid at once in async mode, after the latency count in sync mode
    function automatic logic exp_wait(input logic [15:0] c, input int d);
        logic v;
        v = c[CFG_ASYNC_BIT] || (d > LATENCY_DEF);
        return c[CFG_WPOL_BIT] ? v : !v;
    endfunction : exp_wait
    // sampled on the falling link edge, away from the device's launch edge
    always @(negedge bus.link_clk) begin
        if (!rst && bus.wait_oe === 1'b1) begin
            n_drv = n_drv + 1;
            check("wait", 24'(bus.wait_pin), 24'(exp_wait(cfg, n_drv)));
        end else begin
            n_drv = 0;
        end
    end
    function automatic logic [23:0] exp_addr(input logic two, input logic [23:0] a);
        if (cfg[CFG_EXT_BIT] && mux_strap && two) hi_m = a[23:16];
        return {hi_m, a[15:0]};
    endfunction : exp_addr
    // model drops the upper half whenever the mode goes off
    task automatic set_cfg(input logic [15:0] v, input logic s);
        @(posedge sys_clk) #1;
        cfg = v;
        mux_strap = s;
        if (!(v[CFG_EXT_BIT] && s)) hi_m = '0;
        repeat (40) @(posedge sys_clk);
    endtask : set_cfg
    task automatic do_read(input logic two, input logic [23:0] a);
        int sn;
        int k;
        logic [23:0] e;
        @(posedge sys_clk) #1;
        sn = n_sense;
        e = exp_addr(two, a);
        array_data = 16'($urandom);
        req_two = two;
        req_addr = a;
        req_valid = 1'b1;
        for (k = 0; k < 100 && req_ready !== 1'b1; k++) @(negedge sys_clk);
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
        check("rsp_data", 24'(rsp_data), 24'(array_data));
        check("addr_out", addr_out, e);
        check("senses", 24'(n_sense - sn), 24'h000001);
    endtask : do_read
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h385d));
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        do_read(1'b1, 24'h5a1234);
        $display("test reset_default done");
        set_cfg(16'h8010, 1'b1);
        do_read(1'b0, 24'hff0001);
        do_read(1'b1, 24'hffffff);
        do_read(1'b0, 24'h000000);
        $display("test enable done");
        for (int m = 0; m < 4; m++) begin
            set_cfg(16'h0010 | (m[0] ? 16'h8000 : 16'h0000) | (m[1] ? 16'h0400 : 16'h0000), 1'b1);
            for (int i = 0; i < 10; i++) do_read(1'($urandom_range(1)), 24'($urandom));
        end
        $display("test random_modes done");
        set_cfg(16'h8010, 1'b0);
        do_read(1'b1, 24'h77aaaa);
        set_cfg(16'h8010, 1'b1);
        do_read(1'b1, 24'h3c0000);
        set_cfg(16'h8000, 1'b1);
        set_cfg(16'h8010, 1'b1);
        do_read(1'b0, 24'h00beef);
        $display("test strap_reenable done");
        do_read(1'b1, 24'ha50000);
        @(posedge sys_clk) #1 rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        hi_m = '0;
        do_read(1'b0, 24'h001111);
        $display("test midrun_reset done");
        conclude();
    end
endmodule : muxed_bus_high_address_capture_bench
`default_nettype wire
